/* include/ppio_regs.vh */
`ifndef PPIO_REGS_VH
`define PPIO_REGS_VH

// host port select codes
`define PPIO_SEL_PORT_A 2'h0
`define PPIO_SEL_PORT_B 2'h1
`define PPIO_SEL_PORT_C 2'h2
`define PPIO_SEL_CTRL 2'h3

// mode control word reset value
`define PPIO_MODE_RESET 8'h9B

// mode word field positions
`define PPIO_MW_FLAG 3'h7
`define PPIO_MW_A_MODE_HI 3'h6
`define PPIO_MW_A_MODE_LO 3'h5
`define PPIO_MW_A_IN 3'h4
`define PPIO_MW_CU_IN 3'h3
`define PPIO_MW_B_MODE 3'h2
`define PPIO_MW_B_IN 3'h1
`define PPIO_MW_CL_IN 3'h0

// single-bit command field positions
`define PPIO_BSR_SEL_HI 3'h3
`define PPIO_BSR_SEL_LO 3'h1
`define PPIO_BSR_VAL 3'h0

// port C handshake positions
`define PPIO_PC_B_REQ 3'h0
`define PPIO_PC_B_FULL 3'h1
`define PPIO_PC_B_HS 3'h2
`define PPIO_PC_A_REQ 3'h3
`define PPIO_PC_A_STB 3'h4
`define PPIO_PC_A_IBF 3'h5
`define PPIO_PC_A_ACK 3'h6
`define PPIO_PC_A_OBF 3'h7

`endif

/* hw/ppio_buf.v */
`timescale 1ns/10ps
`default_nettype none
module ppio_buf #(
  parameter W = 8,
  parameter AW = 1
) (
  // clock and control
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire flush,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  localparam DEPTH = 1 << AW;
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp;
  reg [AW:0] rp;
  wire empty;
  wire full;

  assign empty = (wp == rp);
  assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rp[AW-1:0]];

  always @(posedge clk) begin
    if (ce && in_valid && !full) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= {(AW+1){1'b0}};
      rp <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (flush) begin
        wp <= {(AW+1){1'b0}};
        rp <= {(AW+1){1'b0}};
      end else begin
        if (in_valid && !full) begin
          wp <= wp + {{AW{1'b0}}, 1'b1};
        end
        if (out_ready && !empty) begin
          rp <= rp + {{AW{1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* hw/ppio_top.v */
`timescale 1ns/10ps
`default_nettype none
`include "ppio_regs.vh"
module ppio_top (
  // clock, reset, enable
  input wire CLK,
  input wire RST_N,
  input wire CE,
  // host bus
  input wire CS_N,
  input wire RD_N,
  input wire WR_N,
  input wire [1:0] PORT_SELECT,
  input wire [7:0] D_IN,
  output reg [7:0] D_OUT,
  output wire D_OE,
  // port A
  input wire [7:0] PA_IN,
  output reg [7:0] PA_OUT,
  output reg [7:0] PA_OE,
  // port B
  input wire [7:0] PB_IN,
  output reg [7:0] PB_OUT,
  output reg [7:0] PB_OE,
  // port C
  input wire [7:0] PC_IN,
  output reg [7:0] PC_OUT,
  output reg [7:0] PC_OE
);

  function req_next;
    input flag;
    input line_high;
    input enable;
    input host_busy;
    begin
      req_next = flag & line_high & enable & ~host_busy;
    end
  endfunction

  function [7:0] pin_state;
    input [7:0] drv;
    input [7:0] oe;
    input [7:0] pins;
    begin
      pin_state = (drv & oe) | (pins & ~oe);
    end
  endfunction

  reg [7:0] mode_control_word;
  reg [7:0] pa_lat;
  reg [7:0] pb_lat;
  reg [7:0] pc_lat;
  reg group_a_request_enable;
  reg group_b_request_enable;
  reg obf_a_n;
  reg obf_b_n;
  reg sr_a;
  reg sr_b;
  reg rd_q;
  reg wr_q;
  reg [1:0] addr_q;
  reg [7:0] data_q;
  reg stb_a_q;
  reg stb_b_q;
  reg [7:0] next_pc_out;
  reg [7:0] next_pc_oe;
  reg [7:0] next_d_out;
  reg [7:0] wmask;

  wire rd_act = ~CS_N & ~RD_N;
  wire wr_act = ~CS_N & ~WR_N;
  wire rd_rise = rd_q & ~rd_act;
  wire wr_rise = wr_q & ~wr_act;

  // mode 2 is not built; any nonzero group A mode runs the strobed handshake
  wire a_strobed = mode_control_word[`PPIO_MW_A_MODE_HI] |
                   mode_control_word[`PPIO_MW_A_MODE_LO];
  wire b_strobed = mode_control_word[`PPIO_MW_B_MODE];
  wire a_in = mode_control_word[`PPIO_MW_A_IN];
  wire b_in = mode_control_word[`PPIO_MW_B_IN];
  wire cu_in = mode_control_word[`PPIO_MW_CU_IN];
  wire cl_in = mode_control_word[`PPIO_MW_CL_IN];
  wire wr_ctrl = wr_rise && (addr_q == `PPIO_SEL_CTRL);
  wire mode_wr = wr_ctrl && data_q[`PPIO_MW_FLAG];
  wire bsr_wr = wr_ctrl && !data_q[`PPIO_MW_FLAG];
  wire [2:0] bsr_bit = data_q[`PPIO_BSR_SEL_HI:`PPIO_BSR_SEL_LO];
  wire bsr_val = data_q[`PPIO_BSR_VAL];
  wire sel_a_rd = rd_act && (PORT_SELECT == `PPIO_SEL_PORT_A);
  wire sel_b_rd = rd_act && (PORT_SELECT == `PPIO_SEL_PORT_B);
  wire sel_a_wr = wr_act && (PORT_SELECT == `PPIO_SEL_PORT_A);
  wire sel_b_wr = wr_act && (PORT_SELECT == `PPIO_SEL_PORT_B);
  wire stb_a = PC_IN[`PPIO_PC_A_STB];
  wire stb_b = PC_IN[`PPIO_PC_B_HS];
  wire ack_a = PC_IN[`PPIO_PC_A_ACK];
  wire ack_b = PC_IN[`PPIO_PC_B_HS];
  wire a_load = a_strobed & a_in & stb_a_q & ~stb_a;
  wire b_load = b_strobed & b_in & stb_b_q & ~stb_b;
  wire a_pop = a_strobed & a_in & rd_rise & (addr_q == `PPIO_SEL_PORT_A);
  wire b_pop = b_strobed & b_in & rd_rise & (addr_q == `PPIO_SEL_PORT_B);
  wire a_push = a_strobed & ~a_in & wr_rise & (addr_q == `PPIO_SEL_PORT_A);
  wire b_push = b_strobed & ~b_in & wr_rise & (addr_q == `PPIO_SEL_PORT_B);
  wire a_rdy;
  wire b_rdy;
  wire ibf_a;
  wire ibf_b;
  wire [7:0] a_held;
  wire [7:0] b_held;
  assign D_OE = rd_act;

  // a strobe that arrives while both entries are full is refused
  ppio_buf #(.W(8), .AW(1)) u_buf_a (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .flush(mode_wr),
    .in_valid(a_load & a_rdy),
    .in_ready(a_rdy),
    .in_data(PA_IN),
    .out_valid(ibf_a),
    .out_ready(a_pop),
    .out_data(a_held)
  );

  ppio_buf #(.W(8), .AW(1)) u_buf_b (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .flush(mode_wr),
    .in_valid(b_load & b_rdy),
    .in_ready(b_rdy),
    .in_data(PB_IN),
    .out_valid(ibf_b),
    .out_ready(b_pop),
    .out_data(b_held)
  );

  // host bus sampling; writes commit on the closing edge of the strobe
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= `PPIO_SEL_PORT_A;
      data_q <= 8'h00;
      stb_a_q <= 1'b1;
      stb_b_q <= 1'b1;
    end else if (CE) begin
      rd_q <= rd_act;
      wr_q <= wr_act;
      stb_a_q <= stb_a;
      stb_b_q <= stb_b;
      if (rd_act || wr_act) begin
        addr_q <= PORT_SELECT;
      end
      if (wr_act) begin
        data_q <= D_IN;
      end
    end
  end

  always @* begin
    wmask = 8'h00;
    if (!a_strobed && !cu_in) begin
      wmask[7:4] = 4'hF;
    end
    if (!b_strobed && !cl_in) begin
      wmask[2:0] = 3'h7;
      wmask[3] = ~a_strobed;
    end
  end

  // control, latches and enables
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_control_word <= `PPIO_MODE_RESET;
      pa_lat <= 8'h00;
      pb_lat <= 8'h00;
      pc_lat <= 8'h00;
      group_a_request_enable <= 1'b0;
      group_b_request_enable <= 1'b0;
    end else if (CE) begin
      if (mode_wr) begin
        mode_control_word <= data_q;
        pa_lat <= 8'h00;
        pb_lat <= 8'h00;
        pc_lat <= 8'h00;
        group_a_request_enable <= 1'b0;
        group_b_request_enable <= 1'b0;
      end else if (bsr_wr) begin
        pc_lat[bsr_bit] <= bsr_val;
        if (a_strobed && ((a_in && bsr_bit == `PPIO_PC_A_STB) ||
            (!a_in && bsr_bit == `PPIO_PC_A_ACK))) begin
          group_a_request_enable <= bsr_val;
        end
        if (b_strobed && bsr_bit == `PPIO_PC_B_HS) begin
          group_b_request_enable <= bsr_val;
        end
      end else if (wr_rise) begin
        if (addr_q == `PPIO_SEL_PORT_A) begin
          pa_lat <= data_q;
        end else if (addr_q == `PPIO_SEL_PORT_B) begin
          pb_lat <= data_q;
        end else if (addr_q == `PPIO_SEL_PORT_C) begin
          pc_lat <= (pc_lat & ~wmask) | (data_q & wmask);
        end
      end
    end
  end

  // output full flags: the host write sets, acknowledge low clears, set wins
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      obf_a_n <= 1'b1;
      obf_b_n <= 1'b1;
    end else if (CE) begin
      if (mode_wr) begin
        obf_a_n <= 1'b1;
      end else if (a_push) begin
        obf_a_n <= 1'b0;
      end else if (!ack_a) begin
        obf_a_n <= 1'b1;
      end
      if (mode_wr) begin
        obf_b_n <= 1'b1;
      end else if (b_push) begin
        obf_b_n <= 1'b0;
      end else if (!ack_b) begin
        obf_b_n <= 1'b1;
      end
    end
  end

  // service requests; a host read of an input port or a write of an output port, closing edge included, holds them low
  // so that no one-cycle request slips out before the full flag has moved
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sr_a <= 1'b0;
      sr_b <= 1'b0;
    end else if (CE) begin
      if (!a_strobed || mode_wr) begin
        sr_a <= 1'b0;
      end else if (a_in) begin
        sr_a <= req_next(ibf_a, stb_a, group_a_request_enable, sel_a_rd | a_pop);
      end else begin
        sr_a <= req_next(obf_a_n, ack_a, group_a_request_enable, sel_a_wr | a_push);
      end
      if (!b_strobed || mode_wr) begin
        sr_b <= 1'b0;
      end else if (b_in) begin
        sr_b <= req_next(ibf_b, stb_b, group_b_request_enable, sel_b_rd | b_pop);
      end else begin
        sr_b <= req_next(obf_b_n, ack_b, group_b_request_enable, sel_b_wr | b_push);
      end
    end
  end

  // port C line assignment per group mode
  always @* begin
    next_pc_out = pc_lat;
    next_pc_oe = {{4{~cu_in}}, {4{~cl_in}}};
    if (a_strobed) begin
      next_pc_out[`PPIO_PC_A_REQ] = sr_a;
      next_pc_oe[`PPIO_PC_A_REQ] = 1'b1;
      if (a_in) begin
        next_pc_out[`PPIO_PC_A_IBF] = ibf_a;
        next_pc_oe[`PPIO_PC_A_IBF] = 1'b1;
        next_pc_oe[`PPIO_PC_A_STB] = 1'b0;
      end else begin
        next_pc_out[`PPIO_PC_A_OBF] = obf_a_n;
        next_pc_oe[`PPIO_PC_A_OBF] = 1'b1;
        next_pc_oe[`PPIO_PC_A_ACK] = 1'b0;
      end
    end
    if (b_strobed) begin
      next_pc_out[`PPIO_PC_B_REQ] = sr_b;
      next_pc_oe[`PPIO_PC_B_REQ] = 1'b1;
      next_pc_out[`PPIO_PC_B_FULL] = b_in ? ibf_b : obf_b_n;
      next_pc_oe[`PPIO_PC_B_FULL] = 1'b1;
      next_pc_oe[`PPIO_PC_B_HS] = 1'b0;
    end
  end

  // pin drive; data is loaded in the same edge that drops output full
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PA_OUT <= 8'h00;
      PA_OE <= 8'h00;
      PB_OUT <= 8'h00;
      PB_OE <= 8'h00;
      PC_OUT <= 8'h00;
      PC_OE <= 8'h00;
    end else if (CE) begin
      PA_OUT <= pa_lat;
      PA_OE <= {8{~a_in}};
      PB_OUT <= pb_lat;
      PB_OE <= {8{~b_in}};
      PC_OUT <= next_pc_out;
      PC_OE <= next_pc_oe;
    end
  end

  // read data
  always @* begin
    next_d_out = D_OUT;
    if (PORT_SELECT == `PPIO_SEL_PORT_A) begin
      if (!a_in) begin
        next_d_out = pa_lat;
      end else if (a_strobed) begin
        next_d_out = a_held;
      end else begin
        next_d_out = PA_IN;
      end
    end else if (PORT_SELECT == `PPIO_SEL_PORT_B) begin
      if (!b_in) begin
        next_d_out = pb_lat;
      end else if (b_strobed) begin
        next_d_out = b_held;
      end else begin
        next_d_out = PB_IN;
      end
    end else if (PORT_SELECT == `PPIO_SEL_PORT_C) begin
      next_d_out = pin_state(PC_OUT, PC_OE, PC_IN);
      if (a_strobed && a_in) begin
        next_d_out[`PPIO_PC_A_STB] = group_a_request_enable;
      end
      if (a_strobed && !a_in) begin
        next_d_out[`PPIO_PC_A_ACK] = group_a_request_enable;
      end
      if (b_strobed) begin
        next_d_out[`PPIO_PC_B_HS] = group_b_request_enable;
      end
    end else begin
      next_d_out = mode_control_word;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      D_OUT <= 8'h00;
    end else if (CE && rd_act) begin
      D_OUT <= next_d_out;
    end
  end

endmodule
`default_nettype wire

/* tb/ppio_chk_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module ppio_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // host bus
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [1:0] PORT_SELECT,
  input wire logic [7:0] D_IN,
  input wire logic [7:0] D_OUT,
  input wire logic D_OE,
  // ports
  input wire logic [7:0] PA_OUT,
  input wire logic [7:0] PA_OE,
  input wire logic [7:0] PB_OUT,
  input wire logic [7:0] PB_OE,
  input wire logic [7:0] PC_IN,
  input wire logic [7:0] PC_OUT,
  input wire logic [7:0] PC_OE
);
  logic [7:0] mode;
  logic [7:0] pend;
  logic pend_ctrl;
  wire a_in = mode[6:5] == 2'b01 && mode[4];
  wire a_out = mode[6:5] == 2'b01 && !mode[4];

  // shadow of the committed mode word so strobed checks only apply in their mode
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode <= 8'h9B;
      pend <= 8'h00;
      pend_ctrl <= 1'b0;
    end else if (!CS_N && !WR_N) begin
      pend <= D_IN;
      pend_ctrl <= PORT_SELECT == 2'h3;
    end else begin
      pend_ctrl <= 1'b0;
      if (pend_ctrl && pend[7]) mode <= pend;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence host_wr(s);
    !CS_N && !WR_N && PORT_SELECT == s ##1 WR_N;
  endsequence
  sequence basic_mode_wr;
    !CS_N && !WR_N && PORT_SELECT == 2'h3 && D_IN[7:5] == 3'b100 && !D_IN[2] ##1 WR_N;
  endsequence

  bus_drive_a: assert property (
    D_OE == (!CS_N && !RD_N))
    else $error("bus enable wrong");
  reset_inputs_a: assert property (
    $rose(RST_N) |-> {PA_OE, PB_OE, PC_OE} == 24'h0)
    else $error("port driven after reset");
  ctrl_readback_a: assert property (
    !CS_N && !RD_N && PORT_SELECT == 2'h3 |=> D_OUT == mode)
    else $error("control read wrong");
  basic_dir_a: assert property (
    basic_mode_wr |-> ##2 PA_OE == {8{!$past(D_IN[4], 3)}} && PB_OE == {8{!$past(D_IN[1], 3)}}
      && PC_OE == {{4{!$past(D_IN[3], 3)}}, {4{!$past(D_IN[0], 3)}}})
    else $error("direction wrong after mode word");
  mode_clear_a: assert property (
    basic_mode_wr |-> ##2 PA_OUT == 8'h00 && PB_OUT == 8'h00 && PC_OUT == 8'h00)
    else $error("outputs not cleared by mode word");
  latch_full_a: assert property (
    a_in && !PC_IN[4] && $past(PC_IN[4]) |-> ##[2:3] PC_OUT[5])
    else $error("latch full missing after load");
  read_drop_a: assert property (
    a_in && !CS_N && !RD_N && PORT_SELECT == 2'h0 |-> ##[2:3] !PC_OUT[3])
    else $error("request not dropped by read");
  obf_set_a: assert property (
    a_out ##0 host_wr(2'h0) |-> ##2 !PC_OUT[7] && PA_OUT == $past(D_IN, 3))
    else $error("output full or data wrong after write");
  obf_clear_a: assert property (
    a_out && !PC_IN[6] && WR_N && $past(WR_N) |-> ##2 PC_OUT[7])
    else $error("output full not released by acknowledge");
endmodule
`default_nettype wire

/* tb/ppio_periph.sv */
`timescale 1ns/10ps
`default_nettype none
module ppio_periph (
  // clock
  input wire logic clk,
  // levels the block drives
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe,
  // resolved pin levels
  output logic [7:0] pa_pin,
  output logic [7:0] pb_pin,
  output logic [7:0] pc_pin
);
  logic [7:0] drv_a = 8'hFF;
  logic [7:0] drv_b = 8'hFF;
  logic stb_n = 1'b1;
  logic ack_n = 1'b1;

  // lines nobody drives sit high, as the port hold devices keep them
  assign pa_pin = (pa_oe & pa_out) | (~pa_oe & drv_a);
  assign pb_pin = (pb_oe & pb_out) | (~pb_oe & drv_b);
  assign pc_pin = (pc_oe & pc_out) | (~pc_oe & {1'b1, ack_n, 1'b1, stb_n, 4'hF});

  // data is set up an edge before the strobe and held past its rise
  task automatic send(input logic [7:0] v);
    @(posedge clk) #2 drv_a = v;
    @(posedge clk) #2 stb_n = 1'b0;
    @(posedge clk) #2 stb_n = 1'b1;
    @(posedge clk) #2 drv_a = 8'hFF;
  endtask

  task automatic take(output logic [7:0] v, input int dly);
    int i;
    for (i = 0; i < 40 && pc_out[7] !== 1'b0; i++) @(posedge clk);
    repeat (dly) @(posedge clk);
    #2 ack_n = 1'b0;
    v = pa_pin;
    @(posedge clk) #2 ack_n = 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/tb_ppio_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_ppio_top;
  typedef struct packed {
    logic [7:0] mw, ao, bo, co, ra, rb, rc;
  } ppio_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [1:0] sel = 2'h0;
  logic [7:0] d_in = 8'h00;
  logic [7:0] v;
  wire logic [7:0] d_out, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pc_in, pc_out, pc_oe;
  wire logic d_oe;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // mode word, port/C enables, then reads of A, B (also driven as B pins) and C
  ppio_row_t rows [4] = '{
    '{8'h80, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hA5},
    '{8'h91, 8'h00, 8'hFF, 8'hF0, 8'hFF, 8'h00, 8'hAF},
    '{8'h8A, 8'hFF, 8'h00, 8'h0F, 8'h00, 8'h6E, 8'hF5},
    '{8'h9B, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h5A, 8'hFF}};

  ppio_top uut (
    .CLK(clk), .RST_N(rst_n), .CE(1'b1), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
    .PORT_SELECT(sel), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .PA_IN(pa_in),
    .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe),
    .PC_IN(pc_in), .PC_OUT(pc_out), .PC_OE(pc_oe)
  );
  ppio_periph peri (
    .clk(clk), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe),
    .pc_out(pc_out), .pc_oe(pc_oe), .pa_pin(pa_in), .pb_pin(pb_in), .pc_pin(pc_in)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checked %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic do_reset;
    #2 rst_n = 1'b0;
    repeat (16) @(posedge clk);
    #2 rst_n = 1'b1;
  endtask

  // the trailing edge is the commit edge, so each write lands before the next one starts
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk) #2 cs_n = 1'b0;
    wr_n = 1'b0;
    sel = s;
    d_in = d;
    @(posedge clk) #2 cs_n = 1'b1;
    wr_n = 1'b1;
    @(posedge clk) #2;
  endtask

  task automatic rd(input logic [1:0] s, output logic [7:0] r);
    @(posedge clk) #2 cs_n = 1'b0;
    rd_n = 1'b0;
    sel = s;
    @(posedge clk) #2 r = d_out;
    `CHK("d_oe", 1'b1, d_oe)
    cs_n = 1'b1;
    rd_n = 1'b1;
    @(posedge clk) #2;
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #2;
  endtask

  initial begin
    do_reset();
    `CHK("oe", 24'h0, {pa_oe, pb_oe, pc_oe})
    rd(2'h3, v);
    `CHK("mode", 8'h9B, v)
    foreach (rows[i]) begin
      peri.drv_b = rows[i].rb;
      wr(2'h3, rows[i].mw);
      settle();
      `CHK("oe", {rows[i].ao, rows[i].bo, rows[i].co}, {pa_oe, pb_oe, pc_oe})
      rd(2'h0, v);
      `CHK("port_a", rows[i].ra, v)
      rd(2'h1, v);
      `CHK("port_b", rows[i].rb, v)
      wr(2'h2, 8'hA5);
      rd(2'h2, v);
      `CHK("port_c", rows[i].rc, v)
      rd(2'h3, v);
      `CHK("mode", rows[i].mw, v)
      wr(2'h0, 8'h3C);
      wr(2'h1, 8'h3C);
    end
    wr(2'h3, 8'h80);
    for (int i = 0; i < 16; i++) begin
      wr(2'h3, {4'h0, i[2:0], ~i[3]});
      rd(2'h2, v);
      `CHK("bit_op", (i < 8) ? 8'hFF >> (3'd7 - i[2:0]) : 8'hFE << i[2:0], v)
    end
    // group A strobed input; a third word while two are held must be dropped
    wr(2'h3, 8'hB0);
    wr(2'h3, 8'h09);
    rd(2'h2, v);
    `CHK("status", 8'h10, v)
    peri.send(8'h77);
    settle();
    `CHK("full_req", 2'b11, {pc_out[5], pc_out[3]})
    peri.send(8'h88);
    peri.send(8'h99);
    rd(2'h0, v);
    `CHK("in_data", 8'h77, v)
    rd(2'h0, v);
    `CHK("in_data", 8'h88, v)
    settle();
    `CHK("full_req", 2'b00, {pc_out[5], pc_out[3]})
    wr(2'h3, 8'h08);
    peri.send(8'h55);
    settle();
    `CHK("full_req", 2'b10, {pc_out[5], pc_out[3]})
    wr(2'h3, 8'hB0);
    settle();
    rd(2'h2, v);
    `CHK("status", 8'h00, v)
    // group A strobed output, peripheral prompt then slow
    wr(2'h3, 8'hA0);
    wr(2'h3, 8'h0D);
    wr(2'h0, 8'hC3);
    settle();
    `CHK("out_full", 9'h0C3, {pc_out[7], pa_out})
    peri.take(v, 0);
    `CHK("out_data", 8'hC3, v)
    settle();
    `CHK("full_req", 2'b11, {pc_out[7], pc_out[3]})
    wr(2'h0, 8'h3E);
    @(posedge clk) #2;
    `CHK("full_req", 2'b00, {pc_out[7], pc_out[3]})
    peri.take(v, 5);
    `CHK("out_data", 8'h3E, v)
    do_reset();
    rd(2'h3, v);
    `CHK("mode", 8'h9B, v)
    `CHK("oe", 24'h0, {pa_oe, pb_oe, pc_oe})
    give_verdict();
  end
endmodule
bind ppio_top ppio_chk chk (
  .CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
  .PORT_SELECT(PORT_SELECT), .D_IN(D_IN), .D_OUT(D_OUT), .D_OE(D_OE), .PA_OUT(PA_OUT),
  .PA_OE(PA_OE), .PB_OUT(PB_OUT), .PB_OE(PB_OE), .PC_IN(PC_IN), .PC_OUT(PC_OUT), .PC_OE(PC_OE)
);
`default_nettype wire
